/* File: core/emb_bus_iface.v */
`timescale 1ns/1ps
`include "emb_defs.vh"
// Notes on behaviour
// RQ1: Twenty eight shared pins: three ports carry twenty address/data lines, one carries strobes.
// RQ2: Sixteen-bit and multiplexed eight-bit widths; no demultiplexed eight-bit bus.
// RQ3: Bus width comes from a fixed configuration input; software cannot change it.
// RQ4: Disable bit clear enables the bus and removes port functions from pins.
// RQ5: Disable bit set returns the shared pins to ordinary port operation.
// RQ6: Two-bit wait field stretches table cycles; encodings include one and two waits.
// RQ7: Write mode 1x drives full word; high strobe only on odd byte.
// RQ8: Write mode 01 copies byte to both halves; high strobe with one byte enable.
// RQ9: Write mode 00 copies byte to both halves; high or low strobe only.
// RQ10: Control bits 6, 3 and 2 ignore writes and read zero.
// RQ11: Address/data bits 0 to 7 map to port D bits 0 to 7.
// RQ12: Address/data bits 8 to 15 map to port E bits 0 to 7.
// RQ13: Address lines 16 to 19 map to port H bits 0 to 3, never data.
// RQ14: Port J carries latch, output enable, write strobes, byte address, chip and byte enables.
// RQ15: Control register resets with all fields at zero.
// RQ16: Idle bus tri-states lines; strobes high, latch strobe and byte address low.
// RQ17: Disable set from external code waits for internal execution; external access reclaims pins.
// RQ18: Single-chip mode keeps bus off and blocks control writes; full external keeps it on. Here a pending access request still takes the pins.
// RQ19: Chip enable asserts on any external access and stays high during sleep.
// RQ20: Wait count stretches only table cycles, never instruction fetches.
module emb_bus_iface
(
    input  wire        mclk,
    input  wire        reset,
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [1:0]  memMode,
    input  wire        busWidthConfigBit,
    input  wire        sleepMode,
    input  wire        execExternal,
    input  wire        accReq,
    input  wire        accTable,
    input  wire        accWrite,
    input  wire [19:0] tablePointer,
    input  wire [7:0]  tableLatch,
    output wire        accReady,
    output reg         accDone,
    output reg  [15:0] accRdata,
    input  wire [7:0]  portDaOut,
    input  wire [7:0]  portDaOeN,
    input  wire [7:0]  portEbOut,
    input  wire [7:0]  portEbOeN,
    input  wire [3:0]  portHcOut,
    input  wire [3:0]  portHcOeN,
    input  wire [7:0]  portJdOut,
    input  wire [7:0]  portJdOeN,
    input  wire [15:0] adIn,
    output wire [7:0]  portDaPinOut,
    output wire [7:0]  portDaPinOeN,
    output wire [7:0]  portEbPinOut,
    output wire [7:0]  portEbPinOeN,
    output wire [3:0]  portHcPinOut,
    output wire [3:0]  portHcPinOeN,
    output wire [7:0]  portJdPinOut,
    output wire [7:0]  portJdPinOeN,
    output wire        busOwnsPins
);
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_LO   = 3'h2;
    localparam ST_WAIT = 3'h3;
    localparam ST_DATA = 3'h4;

    reg  [7:0]  ctrl_q;
    reg  [2:0]  state_q;
    reg  [1:0]  waitCnt_q;
    reg  [19:0] addr_q;
    reg         table_q;
    reg         write_q;
    reg  [7:0]  tlat_q;
    reg  [7:0]  rdLo_q;
    reg  [15:0] adIn1_q;
    reg  [15:0] adIn2_q;
    reg         awSeen_q;
    reg         wSeen_q;
    reg  [3:0]  awAddr_q;
    reg  [7:0]  wData_q;
    reg         wStrb_q;
    reg         pinsBus_q;
    reg         capture_q;
    reg         ale;
    reg         oeN;
    reg         wrlN;
    reg         wrhN;
    reg         lbN;
    reg         ubN;
    reg         drive;
    reg  [15:0] adOut;
    wire [7:0]  holdByte;
    wire        wordMode;
    wire        eightBit;
    wire        odd;
    wire        holdWr;
    wire        doWrite;

    // Word write mode is selected by the upper write mode bit.
    function isWordMode;
        input [7:0] c;
        begin
            isWordMode = c[`EMB_WM_HI];
        end
    endfunction

    assign eightBit = ~busWidthConfigBit; // [RQ2] [RQ3]
    assign wordMode = isWordMode(ctrl_q);
    assign odd      = addr_q[0];

    // Register slave: address and data are taken in either order.
    assign s_axi_awready = ~awSeen_q & ~s_axi_bvalid;
    assign s_axi_wready  = ~wSeen_q & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign doWrite = awSeen_q & wSeen_q & ~s_axi_bvalid;

    always @(posedge mclk)
    begin
        if (reset)
        begin
            awSeen_q <= 1'b0;
            wSeen_q <= 1'b0;
            awAddr_q <= 4'h0;
            wData_q <= 8'h00;
            wStrb_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `EMB_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `EMB_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            ctrl_q <= `EMB_CTRL_RESET; // [RQ15]
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awSeen_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wSeen_q <= 1'b1;
                wData_q <= s_axi_wdata[7:0];
                wStrb_q <= s_axi_wstrb[0];
            end
            if (doWrite)
            begin
                awSeen_q <= 1'b0;
                wSeen_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (awAddr_q == `EMB_CTRL_ADDR)
                begin
                    s_axi_bresp <= `EMB_RESP_OKAY;
                    if (wStrb_q && memMode != `EMB_MODE_SINGLE) // [RQ18]
                        ctrl_q <= wData_q & `EMB_CTRL_MASK; // [RQ10]
                end
                else if (awAddr_q == `EMB_STAT_ADDR)
                    s_axi_bresp <= `EMB_RESP_OKAY;
                else
                    s_axi_bresp <= `EMB_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `EMB_RESP_OKAY;
                if (s_axi_araddr == `EMB_CTRL_ADDR)
                    s_axi_rdata <= {24'h000000, ctrl_q}; // [RQ10]
                else if (s_axi_araddr == `EMB_STAT_ADDR)
                    s_axi_rdata <= {27'h0000000, pinsBus_q, busWidthConfigBit, state_q == ST_IDLE,
                                    memMode};
                else
                begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `EMB_RESP_SLVERR;
                end
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // External memory cycle sequencer.
    assign accReady = (state_q == ST_IDLE);
    assign holdWr = (state_q == ST_ADDR) && write_q && table_q && wordMode && ~odd;

    emb_hold_latch u_hold
    (
        .mclk   (mclk),
        .reset  (reset),
        .wrEn   (holdWr),
        .wrData (tlat_q),
        .rdData (holdByte)
    );

    always @(posedge mclk)
    begin
        if (reset)
        begin
            adIn1_q <= 16'h0000;
            adIn2_q <= 16'h0000;
        end
        else
        begin
            adIn1_q <= adIn;
            adIn2_q <= adIn1_q;
        end
    end

    always @(posedge mclk)
    begin
        if (reset)
        begin
            state_q <= ST_IDLE;
            waitCnt_q <= 2'h0;
            addr_q <= 20'h00000;
            table_q <= 1'b0;
            write_q <= 1'b0;
            tlat_q <= 8'h00;
            rdLo_q <= 8'h00;
            accDone <= 1'b0;
            accRdata <= 16'h0000;
            pinsBus_q <= 1'b0;
            capture_q <= 1'b0;
        end
        else
        begin
            // Read data are taken one cycle after the data phase, once through the synchroniser.
            accDone <= capture_q;
            capture_q <= 1'b0;
            if (capture_q)
                accRdata <= eightBit ? {adIn2_q[7:0], rdLo_q} : adIn2_q;
            // Pins follow the disable bit only while executing internally.
            if (memMode == `EMB_MODE_EXTFULL || (accReq && accReady))
                pinsBus_q <= 1'b1; // [RQ17] [RQ18]
            else if (memMode == `EMB_MODE_SINGLE)
                pinsBus_q <= 1'b0; // [RQ18]
            else if (!execExternal && state_q == ST_IDLE)
                pinsBus_q <= ~ctrl_q[`EMB_BIT_DISABLE]; // [RQ4] [RQ5] [RQ17]
            case (state_q)
                ST_IDLE:
                begin
                    if (accReq && memMode != `EMB_MODE_SINGLE && !sleepMode)
                    begin
                        addr_q <= tablePointer;
                        table_q <= accTable;
                        write_q <= accWrite & accTable;
                        tlat_q <= tableLatch;
                        state_q <= ST_ADDR;
                    end
                end
                ST_ADDR:
                begin
                    // Tables are stretched by the wait field; fetches never are.
                    waitCnt_q <= table_q ? ctrl_q[`EMB_WAIT_HI:`EMB_WAIT_LO] : 2'h0; // [RQ6] [RQ20]
                    state_q <= (eightBit && !write_q) ? ST_LO : ST_WAIT;
                end
                ST_LO:
                begin
                    rdLo_q <= adIn2_q[7:0];
                    state_q <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    if (waitCnt_q == 2'h0)
                        state_q <= ST_DATA;
                    else
                        waitCnt_q <= waitCnt_q - 2'h1;
                end
                ST_DATA:
                begin
                    capture_q <= 1'b1;
                    state_q <= ST_IDLE;
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // Strobe and data generation per phase.
    always @*
    begin
        ale = (state_q == ST_ADDR);
        oeN = 1'b1;
        wrlN = 1'b1;
        wrhN = 1'b1;
        lbN = 1'b1;
        ubN = 1'b1;
        drive = (state_q == ST_ADDR);
        adOut = addr_q[15:0];
        if ((state_q == ST_LO || state_q == ST_WAIT || state_q == ST_DATA) && !write_q)
        begin
            oeN = 1'b0;
            drive = 1'b0;
            lbN = 1'b0;
            ubN = 1'b0;
        end
        if ((state_q == ST_WAIT || state_q == ST_DATA) && write_q)
        begin
            drive = 1'b1;
            adOut = {tlat_q, tlat_q}; // [RQ8] [RQ9]
            if (eightBit)
            begin
                lbN = 1'b0;
                wrlN = (state_q != ST_DATA);
            end
            else if (wordMode)
            begin
                adOut = {tlat_q, holdByte}; // [RQ7]
                drive = odd;
                lbN = ~odd;
                ubN = ~odd;
                wrhN = ~(odd && state_q == ST_DATA); // [RQ7]
            end
            else if (ctrl_q[`EMB_WM_HI:`EMB_WM_LO] == `EMB_WM_BYTESEL)
            begin
                lbN = odd;
                ubN = ~odd;
                wrhN = (state_q != ST_DATA); // [RQ8]
            end
            else
            begin
                wrhN = ~(odd && state_q == ST_DATA); // [RQ9]
                wrlN = ~(~odd && state_q == ST_DATA); // [RQ9]
            end
        end
    end

    // Pin muxing onto the shared ports.
    assign busOwnsPins = pinsBus_q;
    assign portDaPinOut = pinsBus_q ? adOut[7:0] : portDaOut; // [RQ1] [RQ11]
    assign portDaPinOeN = pinsBus_q ? {8{~drive}} : portDaOeN; // [RQ16]
    assign portEbPinOut = pinsBus_q ? adOut[15:8] : portEbOut; // [RQ12]
    assign portEbPinOeN = pinsBus_q ? {8{~drive}} : portEbOeN; // [RQ16]
    assign portHcPinOut = pinsBus_q ? addr_q[19:16] : portHcOut; // [RQ13]
    assign portHcPinOeN = pinsBus_q ? {4{state_q == ST_IDLE}} : portHcOeN; // [RQ13] [RQ16]
    // Port J order: latch, output enable, low strobe, high strobe, byte, chip, lower, upper.
    assign portJdPinOut = pinsBus_q ? {ubN, lbN, (state_q == ST_IDLE) | sleepMode,
                                       (state_q != ST_IDLE) & addr_q[0], wrhN, wrlN, oeN, ale}
                                    : portJdOut; // [RQ14] [RQ16] [RQ19]
    assign portJdPinOeN = pinsBus_q ? 8'h00 : portJdOeN; // [RQ14]
endmodule

/* File: core/emb_hold_latch.v */
`timescale 1ns/1ps
// Holding latch for the even table latch byte in word write mode.
module emb_hold_latch
(
    input  wire       mclk,
    input  wire       reset,
    input  wire       wrEn,
    input  wire [7:0] wrData,
    output reg  [7:0] rdData
);
    always @(posedge mclk)
    begin
        if (reset)
            rdData <= 8'h00;
        else if (wrEn)
            rdData <= wrData;
    end
endmodule

/* File: inc/emb_defs.vh */
`ifndef EMB_DEFS_VH
`define EMB_DEFS_VH
`define EMB_CTRL_ADDR      4'h0
`define EMB_STAT_ADDR      4'h4
`define EMB_BIT_DISABLE    7
`define EMB_WAIT_HI        5
`define EMB_WAIT_LO        4
`define EMB_WM_HI          1
`define EMB_WM_LO          0
`define EMB_CTRL_MASK      8'hb3
`define EMB_CTRL_RESET     8'h00
`define EMB_MODE_SINGLE    2'h0
`define EMB_MODE_EXTFULL   2'h1
`define EMB_MODE_BOOT      2'h2
`define EMB_MODE_EXTMICRO  2'h3
`define EMB_WM_BYTEWRITE   2'h0
`define EMB_WM_BYTESEL     2'h1
`define EMB_RESP_OKAY      2'h0
`define EMB_RESP_SLVERR    2'h2
`endif

/* File: tb/emb_bus_iface_properties.sv */
`timescale 1ns/1ps
module emb_bus_iface_properties
(
    input wire        mclk,
    input wire        reset,
    input wire [3:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire [1:0]  memMode,
    input wire        sleepMode,
    input wire        busWidthConfigBit,
    input wire        accReq,
    input wire        accTable,
    input wire        accReady,
    input wire        accDone,
    input wire [7:0]  portDaOut,
    input wire [7:0]  portDaPinOut,
    input wire [7:0]  portDaPinOeN,
    input wire [7:0]  portJdPinOut,
    input wire        busOwnsPins
);
    reg [3:0] rdAddr_q;
    always @(posedge mclk)
    begin
        if (s_axi_arvalid && s_axi_arready)
            rdAddr_q <= s_axi_araddr;
    end
    default clocking cbk @(posedge mclk); endclocking
    default disable iff (reset);
    sequence sTake;
        accReq && accReady && memMode != 2'h0 && !sleepMode;
    endsequence
    sequence sFetch;
        sTake ##0 (!accTable && busWidthConfigBit);
    endsequence
    chk_fetch_latency: assert property (sFetch |=> !accDone [*4] ##1 accDone)
        else $error("Fetch did not end four cycles after it was taken.");
    chk_take_reclaim: assert property (sTake |=> busOwnsPins && portJdPinOut[0] && !portJdPinOut[5])
        else $error("Access did not start with pins, latch strobe and chip enable.");
    chk_ce_sleep: assert property (sleepMode |-> portJdPinOut[5] || !busOwnsPins)
        else $error("Chip enable active in sleep.");
    chk_idle_lines: assert property (busOwnsPins && accReady && !accDone |-> portDaPinOeN == 8'hff && portJdPinOut == 8'hee)
        else $error("Idle bus lines in wrong state.");
    chk_port_return: assert property (!busOwnsPins |-> portDaPinOut == portDaOut)
        else $error("Port output not passed to pins.");
    chk_single_chip: assert property ((memMode == 2'h0) [*3] |-> !busOwnsPins)
        else $error("Bus owns pins in single-chip mode.");
    chk_full_ext: assert property ((memMode == 2'h1) [*3] |-> busOwnsPins)
        else $error("Bus released pins in full external mode.");
    chk_strobes_excl: assert property (busOwnsPins |-> portJdPinOut[3:2] != 2'b00)
        else $error("Both write strobes active.");
    chk_reserved_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h0 && rdAddr_q == 4'h0 |-> (s_axi_rdata & 32'hffffff4c) == 32'h0)
        else $error("Reserved control bits read nonzero.");
endmodule
bind emb_bus_iface emb_bus_iface_properties i_props (.*);

/* File: tb/emb_mem_model.sv */
`timescale 1ns/1ps
module emb_mem_model
(
    input wire        mclk,
    input wire [7:0]  portDaPinOut,
    input wire [7:0]  portEbPinOut,
    input wire [3:0]  portHcPinOut,
    input wire [7:0]  portJdPinOut,
    input wire        busOwnsPins,
    output wire [15:0] adIn
);
    reg [15:0] mem [0:15];
    reg [19:0] lastAddr;
    wire [3:0] idx = lastAddr[4:1];
    wire [7:0] j = portJdPinOut;
    integer    i;
    assign adIn = (busOwnsPins && !j[1]) ? mem[idx] : ~mem[idx];
    initial
    begin
        lastAddr = 20'h0;
        for (i = 0; i < 16; i = i + 1)
            mem[i] = {4'hc, i[3:0], 4'h3, ~i[3:0]};
    end
    always @(posedge mclk)
    begin
        if (busOwnsPins && j[0])
            lastAddr <= {portHcPinOut, portEbPinOut, portDaPinOut};
        if (busOwnsPins && !j[3] && !(j[7] && !j[6]))
            mem[idx][15:8] <= portEbPinOut;
        if (busOwnsPins && (!j[2] || (!j[3] && !j[6])))
            mem[idx][7:0] <= portDaPinOut;
    end
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
    reg         mclk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    reg         s_axi_rready, busWidthConfigBit, sleepMode, execExternal, accReq, accTable;
    reg         accWrite;
    reg  [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb, portHcOut, portHcOeN;
    reg  [31:0] s_axi_wdata, rd;
    reg  [1:0]  memMode;
    reg  [19:0] tablePointer, p;
    reg  [7:0]  tableLatch, portDaOut, portDaOeN, portEbOut, portEbOeN, portJdOut, portJdOeN;
    reg  [7:0]  b0, b1, b2;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire        accReady, accDone, busOwnsPins;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [15:0] accRdata, adIn;
    wire [7:0]  portDaPinOut, portDaPinOeN, portEbPinOut, portEbPinOeN, portJdPinOut, portJdPinOeN;
    wire [3:0]  portHcPinOut, portHcPinOeN;
    integer     err_count, n_compared, cyc, n, w;
    emb_bus_iface i_emb_bus_iface (.*);
    emb_mem_model i_mem (.mclk, .portDaPinOut, .portEbPinOut, .portHcPinOut, .portJdPinOut,
                         .busOwnsPins, .adIn);
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    function [15:0] initWord(input [3:0] i);
        initWord = {4'hc, i, 4'h3, ~i};
    endfunction
    function [15:0] expWord(input [1:0] wm, input [7:0] e0, input [7:0] e1, input [7:0] e2);
        expWord = wm[1] ? {e1, e0} : {e1, e2};
    endfunction
    task finish_test;
    begin
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask
    task cmp(input [31:0] got, input [31:0] exp);
    begin
        n_compared = n_compared + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    task axiWr(input [3:0] a, input [31:0] d, input [1:0] er);
        reg       awOk, wOk, awNow, wNow, bOk;
        reg [1:0] resp;
    begin
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        awOk = 1'b0;
        wOk = 1'b0;
        bOk = 1'b0;
        resp = 2'h0;
        while (!(awOk && wOk))
        begin
            @(negedge mclk);
            awNow = s_axi_awready & ~awOk;
            wNow = s_axi_wready & ~wOk;
            @(posedge mclk);
            if (awNow)
            begin
                awOk = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (wNow)
            begin
                wOk = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (!bOk)
        begin
            @(negedge mclk);
            bOk = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge mclk);
        end
        cmp(resp, er);
    end
    endtask
    task axiRd(input [3:0] a, input [1:0] er);
        reg       ok;
        reg [1:0] resp;
    begin
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        ok = 1'b0;
        resp = 2'h0;
        while (!ok)
        begin
            @(negedge mclk);
            ok = s_axi_arready;
            @(posedge mclk);
        end
        s_axi_arvalid <= 1'b0;
        ok = 1'b0;
        while (!ok)
        begin
            @(negedge mclk);
            ok = s_axi_rvalid;
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge mclk);
        end
        cmp(resp, er);
    end
    endtask
    task acc(input t, input wr, input [19:0] a, input [7:0] l, input integer lat);
        reg ok;
    begin
        accReq <= 1'b1;
        accTable <= t;
        accWrite <= wr;
        tablePointer <= a;
        tableLatch <= l;
        ok = 1'b0;
        while (!ok)
        begin
            @(negedge mclk);
            ok = accReady;
            @(posedge mclk);
        end
        accReq <= 1'b0;
        n = 0;
        ok = 1'b0;
        while (!ok)
        begin
            @(negedge mclk);
            ok = accDone;
            @(posedge mclk);
            if (!ok)
                n = n + 1;
        end
        cmp(n, lat);
        cmp(i_mem.lastAddr, a);
    end
    endtask
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count = err_count + 1;
            finish_test;
        end
        {portDaOut, portDaOeN, portEbOut, portEbOeN} <= $urandom;
        {portHcOut, portHcOeN, portJdOut, portJdOeN} <= $urandom;
    end
    initial
    begin
        {reset, s_axi_bready, s_axi_rready, busWidthConfigBit} = 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, sleepMode, execExternal} = 5'h0;
        {accReq, accTable, accWrite, tablePointer, tableLatch} = 31'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, memMode} = 42'h0;
        {portDaOut, portDaOeN, portEbOut, portEbOeN} = 32'h0;
        {portHcOut, portHcOeN, portJdOut, portJdOeN} = 24'h0;
        s_axi_wstrb = 4'hf;
        err_count = 0;
        n_compared = 0;
        cyc = 0;
        rd = $urandom(32'hed96);
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        axiRd(4'h0, 2'h0);
        cmp(rd, 32'h0);
        axiWr(4'h0, 32'hff, 2'h0);
        axiRd(4'h0, 2'h0);
        cmp(rd, 32'h0);
        axiRd(4'h4, 2'h0);
        cmp(rd & 32'hfffffffb, 32'h8);
        memMode <= 2'h3;
        axiWr(4'h0, 32'hffffffff, 2'h0);
        axiRd(4'h0, 2'h0);
        cmp(rd, 32'hb3);
        busWidthConfigBit <= 1'b0;
        axiRd(4'h4, 2'h0);
        cmp(rd & 32'hfffffffb, 32'h3);
        busWidthConfigBit <= 1'b1;
        axiRd(4'h8, 2'h2);
        axiWr(4'hc, 32'h0, 2'h2);
        memMode <= 2'h1;
        repeat (4) @(posedge mclk);
        cmp(busOwnsPins, 1'b1);
        memMode <= 2'h3;
        for (w = 0; w < 4; w = w + 1)
        begin
            axiWr(4'h0, w << 4, 2'h0);
            p = $urandom;
            acc(1'b1, 1'b0, p, 8'h0, 4 + w);
            cmp(accRdata, initWord(p[4:1]));
            acc(1'b0, 1'b0, p, 8'h0, 4);
            cmp(accRdata, initWord(p[4:1]));
        end
        for (w = 0; w < 4; w = w + 1)
        begin
            axiWr(4'h0, w, 2'h0);
            p = $urandom & 32'hffffe;
            {b0, b1, b2} = $urandom;
            acc(1'b1, 1'b1, p, b0, 4);
            acc(1'b1, 1'b1, p | 20'h1, b1, 4);
            acc(1'b1, 1'b1, p, b2, 4);
            acc(1'b1, 1'b0, p, 8'h0, 4);
            cmp(accRdata, expWord(w, b0, b1, b2));
        end
        execExternal <= 1'b1;
        axiWr(4'h0, 32'h80, 2'h0);
        repeat (4) @(posedge mclk);
        cmp(busOwnsPins, 1'b1);
        execExternal <= 1'b0;
        repeat (4) @(posedge mclk);
        cmp(busOwnsPins, 1'b0);
        acc(1'b0, 1'b0, 20'h00012, 8'h0, 4);
        axiWr(4'h0, 32'h0, 2'h0);
        repeat (4) @(posedge mclk);
        cmp(busOwnsPins, 1'b1);
        sleepMode <= 1'b1;
        repeat (5) @(posedge mclk);
        cmp(portJdPinOut[5], 1'b1);
        sleepMode <= 1'b0;
        finish_test;
    end
endmodule
